// File: rtl/psc_config_regs.sv
// Reference, modulus and control register bank of the synthesizer
// Operation
// - Pump current scales with code plus one
// - Halver bit divides reference by two
// - Doubler bit doubles reference frequency
// - Reference divider: five low, five high
// - Twelve-bit modulus, valid two to 4095
// - Buffered fields apply on main divider write
// - Address field in low three bits
// - Top bit chooses write or readback
// - Zero fraction plus auto bit: integer
// - Pump test: normal, source, sink
// - Modulator reset after main divider writes
// - Clamp pump output while pump off
// - Linearity correction off only at 00
// - Mode bit: one integer, zero fractional
// - Lock detect function set by its own bit, apart from mode bit
// - Precision bit: 10ns or 6ns window
// - Polarity bit: zero negative, one positive
// - Power-down bit shuts device down
// - Registers kept during shutdown
`timescale 1ns/1ps
module psc_config_regs
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLoad,
  input wire logic [11:0] fracValue,
  input wire logic [4:0] refDivHigh,
  output logic readOut,
  output logic readActive,
  output logic [3:0] pumpCurrentCode,
  output logic [4:0] pumpCurrentMultiplier,
  output logic referenceHalver,
  output logic referenceDoubler,
  output logic [9:0] refDivValue,
  output logic refDivValid,
  output logic [11:0] modulus,
  output logic modulusValid,
  output logic integerMode,
  output logic modulatorReset,
  output logic pumpForceSource,
  output logic pumpForceSink,
  output logic pumpOutputClamp,
  output logic pumpLinearityEnable,
  output logic lockDetectFunction,
  output logic lockDetectSpeed,
  output logic lockDetectPrecision,
  output logic detectorPolarity,
  output logic powerDownBit,
  output psc_ref_t refModWord,
  output psc_ctrl_t ctrlWord
);

  logic serClkRise;
  logic wordValid;
  logic [31:0] wordData;
  logic isRead;
  logic [2:0] wordAddr;
  logic writeRef;
  logic writeCtrl;
  logic writeMain;
  logic readReq;
  psc_ref_t refShadow_reg;
  psc_ctrl_t ctrl_reg;
  psc_active_t active_reg;
  psc_rb_state_t rbState_reg;
  psc_rb_state_t rbState_next;
  logic [31:0] rbShift_reg;
  logic [5:0] rbCount_reg;
  logic [31:0] rbSelect;

  // Serial word capture
  psc_serial_rx u_rx (
    .mclk(mclk),
    .reset(reset),
    .serClk(serClk),
    .serData(serData),
    .serLoad(serLoad),
    .serClkRise(serClkRise),
    .wordValid(wordValid),
    .wordData(wordData)
  );

  // Word decode: operation bit and address field
  assign isRead = wordData[OP_BIT];
  assign wordAddr = wordData[2:0];
  assign writeRef = wordValid && !isRead && (wordAddr == ADDR_REF_MOD);
  assign writeCtrl = wordValid && !isRead && (wordAddr == ADDR_CTRL);
  assign writeMain = wordValid && !isRead && (wordAddr == ADDR_MAIN_DIV);
  assign readReq = wordValid && isRead;

  // Reference and modulus shadow register; read words leave it intact
  always_ff @(posedge mclk) begin
    if (reset) begin
      refShadow_reg <= psc_ref_t'(RESET_REF_MOD);
    end else if (writeRef) begin
      refShadow_reg <= psc_ref_t'(wordData);
    end
  end

  // Control register; no clear on power-down so settings survive
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= psc_ctrl_t'(RESET_CTRL);
    end else if (writeCtrl) begin
      ctrl_reg <= psc_ctrl_t'(wordData);
    end
  end

  // Buffered fields move to the active copy on a main divider write
  always_ff @(posedge mclk) begin
    if (reset) begin
      active_reg.referenceHalver <= RESET_REF_MOD[21];
      active_reg.referenceDoubler <= RESET_REF_MOD[20];
      active_reg.refDivLow <= RESET_REF_MOD[19:15];
      active_reg.modulus <= RESET_REF_MOD[14:3];
    end else if (writeMain) begin
      active_reg.referenceHalver <= refShadow_reg.referenceHalver;
      active_reg.referenceDoubler <= refShadow_reg.referenceDoubler;
      active_reg.refDivLow <= refShadow_reg.refDivLow;
      active_reg.modulus <= refShadow_reg.modulus;
    end
  end

  // Modulator reset pulse after each main divider write
  always_ff @(posedge mclk) begin
    if (reset) begin
      modulatorReset <= 1'b0;
    end else begin
      modulatorReset <= writeMain && !ctrl_reg.modulatorResetDisable;
    end
  end

  // Pump current code applies at once; multiplier is code plus one
  always_ff @(posedge mclk) begin
    if (reset) begin
      pumpCurrentCode <= RESET_REF_MOD[27:24];
      pumpCurrentMultiplier <= 5'h00;
    end else begin
      pumpCurrentCode <= refShadow_reg.pumpCurrentCode;
      pumpCurrentMultiplier <= {1'b0, refShadow_reg.pumpCurrentCode} + 5'h01;
    end
  end

  // Reference path: halver, doubler and full divider value
  always_ff @(posedge mclk) begin
    if (reset) begin
      referenceHalver <= 1'b0;
      referenceDoubler <= 1'b0;
      refDivValue <= 10'h000;
      refDivValid <= 1'b0;
    end else begin
      referenceHalver <= active_reg.referenceHalver;
      referenceDoubler <= active_reg.referenceDoubler;
      refDivValue <= {refDivHigh, active_reg.refDivLow};
      refDivValid <= {refDivHigh, active_reg.refDivLow} >= REF_DIV_MIN;
    end
  end

  // Fractional modulus and its validity
  always_ff @(posedge mclk) begin
    if (reset) begin
      modulus <= 12'h000;
      modulusValid <= 1'b0;
    end else begin
      modulus <= active_reg.modulus;
      modulusValid <= active_reg.modulus >= MODULUS_MIN;
    end
  end

  // Synthesizer mode including automatic integer on zero fraction
  always_ff @(posedge mclk) begin
    if (reset) begin
      integerMode <= 1'b0;
    end else begin
      integerMode <= ctrl_reg.integerModeBit ||
        (ctrl_reg.autoIntegerOnZeroFraction && (fracValue == 12'h000));
    end
  end

  // Charge pump test, clamp and linearity controls
  always_ff @(posedge mclk) begin
    if (reset) begin
      pumpForceSource <= 1'b0;
      pumpForceSink <= 1'b0;
      pumpOutputClamp <= 1'b0;
      pumpLinearityEnable <= 1'b0;
    end else begin
      pumpForceSource <= ctrl_reg.pumpTestSelect == PUMP_TEST_SOURCE;
      pumpForceSink <= ctrl_reg.pumpTestSelect == PUMP_TEST_SINK;
      pumpOutputClamp <= ctrl_reg.pumpOutputClamp;
      pumpLinearityEnable <= ctrl_reg.pumpLinearitySelect != 2'h0;
    end
  end

  // Lock detect, detector polarity and shutdown
  always_ff @(posedge mclk) begin
    if (reset) begin
      lockDetectFunction <= RESET_CTRL[9];
      lockDetectSpeed <= RESET_CTRL[8];
      lockDetectPrecision <= RESET_CTRL[7];
      detectorPolarity <= RESET_CTRL[6];
      powerDownBit <= RESET_CTRL[5];
    end else begin
      lockDetectFunction <= ctrl_reg.lockDetectFunction;
      lockDetectSpeed <= ctrl_reg.lockDetectSpeed;
      lockDetectPrecision <= ctrl_reg.lockDetectPrecision;
      detectorPolarity <= ctrl_reg.detectorPolarity;
      powerDownBit <= ctrl_reg.powerDownBit;
    end
  end

  // Whole-word views of the stored registers
  assign refModWord = refShadow_reg;
  assign ctrlWord = ctrl_reg;

  // Readback source; addresses outside this bank read as zero
  always_comb begin
    case (wordAddr)
      ADDR_REF_MOD: rbSelect = refShadow_reg;
      ADDR_CTRL: rbSelect = ctrl_reg;
      default: rbSelect = 32'h00000000;
    endcase
  end

  // Readback state decision
  always_comb begin
    rbState_next = rbState_reg;
    case (rbState_reg)
      RB_IDLE: begin
        if (readReq) begin
          rbState_next = RB_SHIFT;
        end
      end
      RB_SHIFT: begin
        if (readReq) begin
          rbState_next = RB_SHIFT;
        end else if (serClkRise && (rbCount_reg == WORD_BITS_COUNT - 6'h01)) begin
          rbState_next = RB_IDLE;
        end
      end
      default: rbState_next = RB_IDLE;
    endcase
  end

  // Readback state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      rbState_reg <= RB_IDLE;
    end else begin
      rbState_reg <= rbState_next;
    end
  end

  // Readback shifter: MSB first, one bit per serial clock rise
  always_ff @(posedge mclk) begin
    if (reset) begin
      rbShift_reg <= 32'h00000000;
      rbCount_reg <= 6'h00;
    end else if (readReq) begin
      rbShift_reg <= rbSelect;
      rbCount_reg <= 6'h00;
    end else if ((rbState_reg == RB_SHIFT) && serClkRise) begin
      rbShift_reg <= {rbShift_reg[30:0], 1'b0};
      rbCount_reg <= rbCount_reg + 6'h01;
    end
  end

  // Readback pin and busy flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      readOut <= 1'b0;
      readActive <= 1'b0;
    end else begin
      readOut <= readReq ? rbSelect[31] : ((rbState_next == RB_SHIFT) ? rbShift_reg[31] : 1'b0);
      readActive <= rbState_next == RB_SHIFT;
    end
  end

endmodule : psc_config_regs

// File: rtl/psc_pkg.sv
// Shared constants and types for the synthesizer configuration registers
package psc_pkg;

  // Serial word geometry
  localparam int unsigned WORD_BITS = 32;
  localparam logic [5:0] WORD_BITS_COUNT = 6'h20;
  localparam logic [5:0] BIT_COUNT_MAX = 6'h3f;
  localparam int unsigned OP_BIT = 31;

  // Register address codes carried in bits 2:0
  localparam logic [2:0] ADDR_MAIN_DIV = 3'h0;
  localparam logic [2:0] ADDR_REF_MOD = 3'h2;
  localparam logic [2:0] ADDR_CTRL = 3'h3;

  // Values after reset
  localparam logic [31:0] RESET_REF_MOD = 32'h0000fffa;
  localparam logic [31:0] RESET_CTRL = 32'h00000043;

  // Field limits
  localparam logic [9:0] REF_DIV_MIN = 10'h001;
  localparam logic [11:0] MODULUS_MIN = 12'h002;
  localparam logic [1:0] PUMP_TEST_NORMAL = 2'h0;
  localparam logic [1:0] PUMP_TEST_SOURCE = 2'h2;
  localparam logic [1:0] PUMP_TEST_SINK = 2'h3;

  // Reference and modulus register layout
  typedef struct packed {
    logic readRequest;
    logic [1:0] noiseMode;
    logic slipReduction;
    logic [3:0] pumpCurrentCode;
    logic [1:0] factoryBits;
    logic referenceHalver;
    logic referenceDoubler;
    logic [4:0] refDivLow;
    logic [11:0] modulus;
    logic [2:0] addr;
  } psc_ref_t;

  // Control register layout
  typedef struct packed {
    logic readRequest;
    logic [12:0] unusedBits;
    logic autoIntegerOnZeroFraction;
    logic [1:0] pumpTestSelect;
    logic modulatorResetDisable;
    logic pumpOutputClamp;
    logic [1:0] pumpLinearitySelect;
    logic integerModeBit;
    logic lockDetectFunction;
    logic lockDetectSpeed;
    logic lockDetectPrecision;
    logic detectorPolarity;
    logic powerDownBit;
    logic pumpTristate;
    logic counterReset;
    logic [2:0] addr;
  } psc_ctrl_t;

  // Double-buffered fields that take effect on a main divider write
  typedef struct packed {
    logic referenceHalver;
    logic referenceDoubler;
    logic [4:0] refDivLow;
    logic [11:0] modulus;
  } psc_active_t;

  // Readback shifter states
  typedef enum logic [1:0] {
    RB_IDLE = 2'b01,
    RB_SHIFT = 2'b10
  } psc_rb_state_t;

endpackage : psc_pkg

// File: rtl/psc_serial_rx.sv
// Three-wire serial word receiver for the configuration registers
`timescale 1ns/1ps
module psc_serial_rx
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLoad,
  output logic serClkRise,
  output logic wordValid,
  output logic [31:0] wordData
);

  logic serClkPrev_reg;
  logic serLoadPrev_reg;
  logic [31:0] shift_reg;
  logic [5:0] bitCount_reg;
  logic loadRise;

  // Edge detection on the sampled serial pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      serClkPrev_reg <= 1'b0;
      serLoadPrev_reg <= 1'b1; // Idle level of load, no false rise after reset
    end else begin
      serClkPrev_reg <= serClk;
      serLoadPrev_reg <= serLoad;
    end
  end

  assign serClkRise = serClk & ~serClkPrev_reg;
  assign loadRise = serLoad & ~serLoadPrev_reg;

  // Shift in MSB first while load is low; count saturates
  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_reg <= 32'h00000000;
      bitCount_reg <= 6'h00;
    end else if (loadRise) begin
      bitCount_reg <= 6'h00;
    end else if (serClkRise && !serLoad) begin
      shift_reg <= {shift_reg[30:0], serData};
      if (bitCount_reg != BIT_COUNT_MAX) begin
        bitCount_reg <= bitCount_reg + 6'h01;
      end
    end
  end

  // Word is handed over only when exactly 32 bits arrived
  always_ff @(posedge mclk) begin
    if (reset) begin
      wordValid <= 1'b0;
      wordData <= 32'h00000000;
    end else begin
      wordValid <= loadRise && (bitCount_reg == WORD_BITS_COUNT);
      if (loadRise && (bitCount_reg == WORD_BITS_COUNT)) begin
        wordData <= shift_reg;
      end
    end
  end

endmodule : psc_serial_rx

// File: tb/psc_config_regs_sva.sv
// Port-level checks for the configuration register bank
`timescale 1ns/1ps
module psc_config_regs_sva
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [11:0] fracValue,
  input wire logic readOut,
  input wire logic readActive,
  input wire logic [4:0] pumpCurrentMultiplier,
  input wire logic [9:0] refDivValue,
  input wire logic refDivValid,
  input wire logic [11:0] modulus,
  input wire logic modulusValid,
  input wire logic integerMode,
  input wire logic modulatorReset,
  input wire logic pumpForceSource,
  input wire logic pumpForceSink,
  input wire logic pumpLinearityEnable,
  input wire logic detectorPolarity,
  input wire logic powerDownBit,
  input wire psc_ref_t refModWord,
  input wire psc_ctrl_t ctrlWord
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Derived outputs follow the stored words one edge later; valid flags match their values in the same cycle
  property p_mult; !$past(reset) |-> pumpCurrentMultiplier == {1'b0, $past(refModWord.pumpCurrentCode)} + 5'h01; endproperty
  a_mult: assert property (p_mult) else $error("multiplier is not code plus one");
  property p_src; pumpForceSource == ($past(ctrlWord.pumpTestSelect) == PUMP_TEST_SOURCE); endproperty
  a_src: assert property (p_src) else $error("source forcing wrong");
  property p_sink; pumpForceSink == ($past(ctrlWord.pumpTestSelect) == PUMP_TEST_SINK); endproperty
  a_sink: assert property (p_sink) else $error("sink forcing wrong");
  property p_lin; pumpLinearityEnable == ($past(ctrlWord.pumpLinearitySelect) != 2'h0); endproperty
  a_lin: assert property (p_lin) else $error("linearity enable wrong");
  property p_int;
    integerMode == $past(ctrlWord.integerModeBit | (ctrlWord.autoIntegerOnZeroFraction & (fracValue == 12'h000)));
  endproperty
  a_int: assert property (p_int) else $error("integer mode wrong");
  property p_power_down_bit; {powerDownBit, detectorPolarity} == $past({ctrlWord.powerDownBit, ctrlWord.detectorPolarity}); endproperty
  a_power_down_bit: assert property (p_power_down_bit) else $error("power or polarity copy wrong");
  property p_rvalid; refDivValid == (refDivValue >= REF_DIV_MIN); endproperty
  a_rvalid: assert property (p_rvalid) else $error("divider valid flag wrong");
  property p_mvalid; modulusValid == (modulus >= MODULUS_MIN); endproperty
  a_mvalid: assert property (p_mvalid) else $error("modulus valid flag wrong");
  // Active modulus only ever takes the stored shadow value
  property p_buf; $changed(modulus) |-> modulus == $past(refModWord.modulus); endproperty
  a_buf: assert property (p_buf) else $error("modulus not from shadow");
  property p_mrst; modulatorReset |-> !ctrlWord.modulatorResetDisable ##1 !modulatorReset; endproperty
  a_mrst: assert property (p_mrst) else $error("modulator reset pulse wrong");
  // Stored words always carry the write code in their top bit
  property p_rb; $rose(readActive) |-> !readOut; endproperty
  a_rb: assert property (p_rb) else $error("readback first bit not zero");
endmodule : psc_config_regs_sva

bind psc_config_regs psc_config_regs_sva chk (.mclk, .reset, .fracValue, .readOut, .readActive,
  .pumpCurrentMultiplier, .refDivValue, .refDivValid, .modulus, .modulusValid, .integerMode, .modulatorReset,
  .pumpForceSource, .pumpForceSink, .pumpLinearityEnable, .detectorPolarity, .powerDownBit, .refModWord, .ctrlWord);

// File: tb/psc_host_model.sv
// Host controller model driving the three-wire serial link
`timescale 1ns/1ps
module psc_host_model (
  input wire logic mclk,
  input wire logic readOut,
  output logic serClk,
  output logic serData,
  output logic serLoad
);
  // Idle link: clock low, load high
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    serLoad = 1'b1;
  end
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step
  // Shift n bits MSB first, then raise load to end the word
  task automatic send(input logic [31:0] w, input int n);
    step(1);
    serLoad = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serData = w[i];
      step(2);
      serClk = 1'b1;
      step(2);
      serClk = 1'b0;
    end
    step(2);
    serLoad = 1'b1;
    serData = ~serData;
    step(6);
  endtask : send
  // Read request, then clock the answer out with load high
  task automatic readback(input logic [31:0] w, output logic [31:0] r);
    send(w, 32);
    for (int i = 31; i >= 0; i--) begin
      r[i] = readOut;
      serClk = 1'b1;
      step(2);
      serClk = 1'b0;
      step(2);
    end
  endtask : readback
endmodule : psc_host_model

// File: tb/tb_psc_config_regs.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_psc_config_regs;
  import psc_pkg::*;
  logic mclk, reset, serClk, serData, serLoad, readOut, readActive, referenceHalver, referenceDoubler;
  logic refDivValid, modulusValid, integerMode, modulatorReset, pumpForceSource, pumpForceSink;
  logic pumpOutputClamp, pumpLinearityEnable, lockDetectFunction, lockDetectSpeed, lockDetectPrecision;
  logic detectorPolarity, powerDownBit;
  logic [11:0] fracValue, modulus;
  logic [4:0] refDivHigh, pumpCurrentMultiplier;
  logic [3:0] pumpCurrentCode;
  logic [9:0] refDivValue;
  logic [31:0] cw, rd;
  psc_ref_t refModWord;
  psc_ctrl_t ctrlWord;
  int err_count, n_checks, mrstCount;
  psc_config_regs dut (.mclk, .reset, .serClk, .serData, .serLoad, .fracValue, .refDivHigh, .readOut,
    .readActive, .pumpCurrentCode, .pumpCurrentMultiplier, .referenceHalver, .referenceDoubler, .refDivValue,
    .refDivValid, .modulus, .modulusValid, .integerMode, .modulatorReset, .pumpForceSource, .pumpForceSink,
    .pumpOutputClamp, .pumpLinearityEnable, .lockDetectFunction, .lockDetectSpeed, .lockDetectPrecision,
    .detectorPolarity, .powerDownBit, .refModWord, .ctrlWord);
  psc_host_model host (.mclk, .readOut, .serClk, .serData, .serLoad);
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic results();
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // Count modulator reset pulses away from the launching edge
  always @(negedge mclk) begin
    if (modulatorReset === 1'b1) begin
      mrstCount++;
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    results();
  end
  // Main sequence; host keeps factory and unused bits at zero
  initial begin
    err_count = 0;
    n_checks = 0;
    mrstCount = 0;
    reset = 1'b1;
    fracValue = 12'h005;
    refDivHigh = 5'h03;
    repeat (10) @(posedge mclk);
    #1 reset = 1'b0;
    host.step(2);
    chk(ctrlWord, 32'h00000043);
    chk(refModWord, RESET_REF_MOD);
    chk(detectorPolarity, 1);
    for (int c = 0; c < 4; c++) begin
      cw = 32'h00002b83 | (c << 15);
      host.send(cw, 32);
      chk(ctrlWord, cw);
      chk({pumpForceSource, pumpForceSink}, {c == 2, c == 3});
      chk({pumpOutputClamp, pumpLinearityEnable, lockDetectFunction, lockDetectSpeed, lockDetectPrecision}, 5'h1f);
      chk({integerMode, detectorPolarity}, 2'h0);
    end
    cw = 32'h00022b83;
    host.send(cw, 32);
    chk(integerMode, 0);
    fracValue = 12'h000;
    host.step(2);
    chk(integerMode, 1);
    fracValue = 12'h005;
    cw = 32'h00000443;
    host.send(cw, 32);
    chk({integerMode, pumpLinearityEnable, detectorPolarity}, 3'h5);
    host.send(32'h0928891a, 32);
    chk(refModWord, 32'h0928891a);
    chk(pumpCurrentMultiplier, 5'h0a);
    chk(pumpCurrentCode, 4'h9);
    chk(modulus, 12'hfff);
    host.send(32'h00000000, 32);
    chk({referenceHalver, referenceDoubler, modulus}, {2'h2, 12'h123});
    chk({refDivValid, modulusValid, refDivValue}, {2'h3, 10'h071});
    host.send(32'h0000000a, 32);
    host.send(32'h00000000, 32);
    refDivHigh = 5'h00;
    host.step(2);
    chk({refDivValid, modulusValid, modulus}, {2'h0, 12'h001});
    chk(mrstCount, 2);
    host.send(32'h00000013, 31);
    host.send(32'h0000ff05, 32);
    chk(ctrlWord, cw);
    chk(refModWord, 32'h0000000a);
    host.readback(32'h80000003, rd);
    chk(rd, cw);
    chk(readActive, 0);
    host.readback(32'h80000005, rd);
    chk(rd, 32'h00000000);
    host.send(32'h00004063, 32);
    chk({powerDownBit, detectorPolarity}, 2'h3);
    host.send(32'h00000000, 32);
    chk(mrstCount, 2);
    host.readback(32'h80000002, rd);
    chk(rd, 32'h0000000a);
    results();
  end
endmodule : tb_psc_config_regs
